// ---- rtl/dram_lane_pkg.sv ----
package dram_lane_pkg;

   // bus geometry
   localparam int DQ_W           = 36;
   localparam int LANE_W         = 18;

   // core clock and free-running output data clock
   localparam int CORE_PERIOD_NS = 20;
   localparam int QK_HALF_NS     = 80;
   localparam int QK_HALF_CYC    = (QK_HALF_NS / CORE_PERIOD_NS < 1) ? 1 :
                                   QK_HALF_NS / CORE_PERIOD_NS;
   localparam int QK_CNT_W       = 8;

   // beats moved per read or write command
   localparam int BURST_BEATS    = 2;
   localparam int CNT_W          = 6;

   // bits of the bus that carry data in each width option
   localparam logic [DQ_W-1:0] LIVE_X9  = 36'h0_0000_01ff;
   localparam logic [DQ_W-1:0] LIVE_X18 = 36'h0_0003_ffff;
   localparam logic [DQ_W-1:0] LIVE_X36 = 36'hf_ffff_ffff;

   // reset values and read buffer depth
   localparam logic [DQ_W-1:0] DQ_RST    = 36'h0_0000_0000;
   localparam logic [1:0]      SYNC_RST  = 2'h0;
   localparam logic [1:0]      BUF_DEPTH = 2'h2;

   typedef enum logic [1:0] {
      MODE_X9,
      MODE_X18,
      MODE_X36
   } width_mode_t;

   typedef enum logic [1:0] {
      CMD_READ,
      CMD_WRITE,
      CMD_REFRESH,
      CMD_MODE_SET
   } cmd_kind_t;

   typedef struct packed {
      logic      valid;
      cmd_kind_t kind;
   } cmd_t;

   typedef struct packed {
      logic            valid;
      logic [DQ_W-1:0] data;
   } word_t;

   typedef struct packed {
      logic clk;
      logic clk_n;
   } clk_pair_t;

endpackage : dram_lane_pkg

// ---- rtl/ddr_lane_sampler.sv ----
module ddr_lane_sampler #(
   parameter int W = 18
) (
   input  wire logic         i_core_clk,
   input  wire logic         i_rst,
   input  wire logic         i_data_clk,
   input  wire logic [W-1:0] i_data,
   output logic              o_beat_valid,
   output logic [W-1:0]      o_beat
);
   import dram_lane_pkg::*;

   typedef struct packed {
      logic [1:0]   clk_s;
      logic         clk_prev;
      logic [W-1:0] data_s0;
      logic [W-1:0] data_s1;
      logic         valid;
      logic [W-1:0] beat;
   } lane_state_t;

   lane_state_t s_q;
   lane_state_t s_d;

   // two-stage sync of clock and data, beat taken on either clock edge
   always_comb begin
      s_d          = s_q;
      s_d.clk_s    = {s_q.clk_s[0], i_data_clk};
      s_d.data_s0  = i_data;
      s_d.data_s1  = s_q.data_s0;
      s_d.clk_prev = s_q.clk_s[1];
      s_d.valid    = s_q.clk_s[1] ^ s_q.clk_prev;
      if (s_q.clk_s[1] ^ s_q.clk_prev) begin
         s_d.beat = s_q.data_s1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_beat_valid = s_q.valid;
   assign o_beat       = s_q.beat;

endmodule : ddr_lane_sampler

// ---- rtl/dram_data_lane_interface.sv ----
// Behaviour
// - a write beat sampled with write mask high is dropped, not stored
// - write mask taken on both data clock edges; second clock in x36
// - write, refresh and chip select sampled on input clock rising edge
// - read beats driven on both edges of the output data clock
// - write data sampled on both input data clock edges, one per edge
// - data bus is 36 bits, input on writes, output on reads
// - output data clock pair toggles always, opposite polarity, read aligned
// - x36: first output clock pair bits 0-17, second pair 18-35
// - x18: first output clock pair bits 0-8, second pair 9-17
// - x9: all data bits aligned with the first output clock pair
// - read valid high exactly while valid read data is on the bus
// - read valid changes on output data clock edges
// - chip select high ignores new commands, running bursts go on
module dram_data_lane_interface
   import dram_lane_pkg::*;
#(
   parameter dram_lane_pkg::width_mode_t WIDTH_MODE =
      dram_lane_pkg::MODE_X36,
   parameter int                         BURST      =
      dram_lane_pkg::BURST_BEATS,
   parameter int                         QK_HALF    =
      dram_lane_pkg::QK_HALF_CYC
) (
   input  wire logic                       i_core_clk,
   input  wire logic                       i_rst,
   // pins to and from the controller
   input  wire logic                       i_input_clock,
   input  wire logic                       i_cs_n,
   input  wire logic                       i_we_n,
   input  wire logic                       i_ref_n,
   input  wire logic                       i_input_data_clock0,
   input  wire logic                       i_input_data_clock1,
   input  wire logic                       i_write_mask_in,
   input  wire logic [dram_lane_pkg::DQ_W-1:0] i_dq,
   output logic [dram_lane_pkg::DQ_W-1:0]  o_dq,
   output logic                            o_dq_oe,
   output dram_lane_pkg::clk_pair_t        o_output_data_clock0,
   output dram_lane_pkg::clk_pair_t        o_output_data_clock1,
   output logic                            o_read_valid_out,
   // core side
   output dram_lane_pkg::cmd_t             o_cmd,
   output dram_lane_pkg::word_t            o_wr,
   input  wire dram_lane_pkg::word_t       i_rd,
   output logic                            o_rd_ready
);
   import dram_lane_pkg::*;

   localparam logic [DQ_W-1:0] LIVE =
      (WIDTH_MODE == MODE_X9)  ? LIVE_X9  :
      (WIDTH_MODE == MODE_X18) ? LIVE_X18 : LIVE_X36;
   localparam logic [CNT_W-1:0]    BURST_N   = CNT_W'(BURST);
   localparam logic [QK_CNT_W-1:0] QK_LAST   = QK_CNT_W'(QK_HALF - 1);

   typedef struct packed {
      logic [1:0]            ck_s;
      logic                  ck_prev;
      logic [1:0]            cs_s;
      logic [1:0]            we_s;
      logic [1:0]            ref_s;
      cmd_t                  cmd;
      logic [CNT_W-1:0]      wr_left;
      logic [CNT_W-1:0]      rd_left;
      logic                  pend0;
      logic                  pend1;
      logic [LANE_W-1:0]     hold0;
      logic [LANE_W:0]       hold1;
      word_t                 wr;
      logic [QK_CNT_W-1:0]   qk_cnt;
      logic                  qk;
      logic [1:0][DQ_W-1:0]  buf_mem;
      logic                  buf_wp;
      logic                  buf_rp;
      logic [1:0]            buf_cnt;
      logic [DQ_W-1:0]       dq;
      logic                  dq_oe;
      logic                  rd_valid;
   } state_t;

   state_t              s_q;
   state_t              s_d;
   logic                lane0_v;
   logic                lane1_v;
   logic [LANE_W-1:0]   lane0_beat;
   logic [LANE_W:0]     lane1_beat;
   logic                lane1_clk;
   logic                ck_rise;
   logic                qk_edge;
   logic                push;
   logic                pop;

   // lower half of the bus always on the first data clock
   ddr_lane_sampler #(
      .W (LANE_W)
   ) u_lane0 (
      .i_core_clk   (i_core_clk),
      .i_rst        (i_rst),
      .i_data_clk   (i_input_data_clock0),
      .i_data       (i_dq[LANE_W-1:0]),
      .o_beat_valid (lane0_v),
      .o_beat       (lane0_beat)
   );

   // upper half and mask follow the second data clock only in x36
   assign lane1_clk = (WIDTH_MODE == MODE_X36) ? i_input_data_clock1 :
                                                 i_input_data_clock0;

   ddr_lane_sampler #(
      .W (LANE_W + 1)
   ) u_lane1 (
      .i_core_clk   (i_core_clk),
      .i_rst        (i_rst),
      .i_data_clk   (lane1_clk),
      .i_data       ({i_write_mask_in, i_dq[DQ_W-1:LANE_W]}),
      .o_beat_valid (lane1_v),
      .o_beat       (lane1_beat)
   );

   assign ck_rise = s_q.ck_s[1] & ~s_q.ck_prev;
   assign qk_edge = (s_q.qk_cnt == QK_LAST);
   assign push    = i_rd.valid & (s_q.buf_cnt != BUF_DEPTH);
   assign pop     = qk_edge & (s_q.rd_left != '0) & (s_q.buf_cnt != 2'h0);

   // next-state logic for commands, write beats, buffer and read lanes
   always_comb begin
      s_d           = s_q;
      s_d.cmd.valid = 1'b0;
      s_d.wr.valid  = 1'b0;

      // pin synchronisers; stage 0 feeds only stage 1
      s_d.ck_s    = {s_q.ck_s[0], i_input_clock};
      s_d.cs_s    = {s_q.cs_s[0], i_cs_n};
      s_d.we_s    = {s_q.we_s[0], i_we_n};
      s_d.ref_s   = {s_q.ref_s[0], i_ref_n};
      s_d.ck_prev = s_q.ck_s[1];

      // command decode on input clock rising edge with chip select low
      if (ck_rise && !s_q.cs_s[1]) begin
         s_d.cmd.valid = 1'b1;
         unique case ({s_q.we_s[1], s_q.ref_s[1]})
            2'b11: begin
               s_d.cmd.kind = CMD_READ;
               s_d.rd_left  = s_q.rd_left + BURST_N;
            end
            2'b01: begin
               s_d.cmd.kind = CMD_WRITE;
               s_d.wr_left  = s_q.wr_left + BURST_N;
            end
            2'b10: begin
               s_d.cmd.kind = CMD_REFRESH;
            end
            2'b00: begin
               s_d.cmd.kind = CMD_MODE_SET;
            end
         endcase
      end

      // gather both lane halves of a write beat, they may be skewed
      if (lane0_v) begin
         s_d.pend0 = 1'b1;
         s_d.hold0 = lane0_beat;
      end
      if (lane1_v) begin
         s_d.pend1 = 1'b1;
         s_d.hold1 = lane1_beat;
      end
      if (s_d.pend0 && s_d.pend1) begin
         s_d.pend0 = 1'b0;
         s_d.pend1 = 1'b0;
         if (s_q.wr_left != '0) begin
            s_d.wr_left = s_d.wr_left - 1'b1;
            if (!s_d.hold1[LANE_W]) begin
               s_d.wr.valid = 1'b1;
               s_d.wr.data  = {s_d.hold1[LANE_W-1:0], s_d.hold0} & LIVE;
            end
         end
      end

      // two-entry read buffer: the core fills, output clock edges drain
      if (push) begin
         s_d.buf_mem[s_q.buf_wp] = i_rd.data;
         s_d.buf_wp              = ~s_q.buf_wp;
      end
      if (pop) begin
         s_d.buf_rp = ~s_q.buf_rp;
      end
      s_d.buf_cnt = s_q.buf_cnt + {1'b0, push} - {1'b0, pop};

      // free-running output data clock from the core clock divider
      if (qk_edge) begin
         s_d.qk_cnt = '0;
         s_d.qk     = ~s_q.qk;
         // data and valid change only together with a clock edge
         if (pop) begin
            s_d.dq       = s_q.buf_mem[s_q.buf_rp] & LIVE;
            s_d.dq_oe    = 1'b1;
            s_d.rd_valid = 1'b1;
            s_d.rd_left  = s_d.rd_left - 1'b1;
         end else begin
            s_d.dq_oe    = 1'b0;
            s_d.rd_valid = 1'b0;
         end
      end else begin
         s_d.qk_cnt = s_q.qk_cnt + 1'b1;
      end
   end

   // state register
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // both pairs come from one divider so every lane group is edge aligned
   assign o_output_data_clock0.clk   = s_q.qk;
   assign o_output_data_clock0.clk_n = ~s_q.qk;
   assign o_output_data_clock1.clk   = s_q.qk;
   assign o_output_data_clock1.clk_n = ~s_q.qk;
   assign o_dq             = s_q.dq;
   assign o_dq_oe          = s_q.dq_oe;
   assign o_read_valid_out = s_q.rd_valid;
   assign o_cmd            = s_q.cmd;
   assign o_wr             = s_q.wr;
   assign o_rd_ready       = (s_q.buf_cnt != BUF_DEPTH);

endmodule : dram_data_lane_interface

// ---- sim/dram_data_lane_interface_checker.sv ----
module dram_data_lane_interface_checker
   import dram_lane_pkg::*;
#(
   parameter int QK_HALF = 4
) (
   input wire logic                     i_core_clk,
   input wire logic                     i_rst,
   input wire logic                     i_input_clock,
   input wire logic                     i_cs_n,
   input wire logic [DQ_W-1:0]          o_dq,
   input wire logic                     o_dq_oe,
   input wire dram_lane_pkg::clk_pair_t o_output_data_clock0,
   input wire dram_lane_pkg::clk_pair_t o_output_data_clock1,
   input wire logic                     o_read_valid_out,
   input wire dram_lane_pkg::cmd_t      o_cmd,
   input wire dram_lane_pkg::word_t     o_wr
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   logic [7:0] hold_q;
   logic       qk_q;
   // cycles since the first output clock last toggled
   always_ff @(posedge i_core_clk) begin
      qk_q <= o_output_data_clock0.clk;
      if (i_rst || qk_q != o_output_data_clock0.clk)
         hold_q <= 8'h0;
      else
         hold_q <= hold_q + 8'h1;
   end
   chk_qk_opposite: assert property (
      o_output_data_clock0.clk != o_output_data_clock0.clk_n)
      else $error("output clock halves not opposite");
   chk_qk_pairs_match: assert property (
      o_output_data_clock1 == o_output_data_clock0)
      else $error("output clock pairs differ");
   chk_qk_free_run: assert property (hold_q <= QK_HALF)
      else $error("output clock stopped");
   chk_valid_oe_match: assert property (o_read_valid_out == o_dq_oe)
      else $error("read valid and drive enable differ");
   chk_valid_edge_aligned: assert property (
      $changed(o_read_valid_out) |-> $changed(o_output_data_clock0.clk))
      else $error("read valid moved off a clock edge");
   chk_dq_half_held: assert property (
      o_dq_oe && !$changed(o_output_data_clock0.clk) |-> $stable(o_dq))
      else $error("read data moved within a half period");
   chk_cmd_one_cycle: assert property (o_cmd.valid |=> !o_cmd.valid)
      else $error("command pulse too long");
   chk_cmd_needs_select: assert property (
      o_cmd.valid |-> !$past(i_cs_n, 3))
      else $error("command taken while deselected");
   chk_cmd_after_clock: assert property (
      o_cmd.valid |-> $past(i_input_clock, 3))
      else $error("command without an input clock rise");
   chk_wr_one_cycle: assert property (o_wr.valid |=> !o_wr.valid)
      else $error("write beat pulse too long");
   cover property (o_cmd.valid);
   cover property (o_wr.valid);
   cover property ($rose(o_read_valid_out));
endmodule : dram_data_lane_interface_checker

// ---- sim/ctrl_model.sv ----
module ctrl_model (
   input  wire logic                            i_core_clk,
   input  wire logic                            i_qk,
   input  wire logic                            i_read_valid_out,
   input  wire logic [dram_lane_pkg::DQ_W-1:0]  i_dq,
   output logic                                 o_input_clock,
   output logic                                 o_cs_n,
   output logic                                 o_we_n,
   output logic                                 o_ref_n,
   output logic                                 o_dk0,
   output logic                                 o_dk1,
   output logic                                 o_mask,
   output logic [dram_lane_pkg::DQ_W-1:0]       o_dq
);
   timeunit 1ns;
   timeprecision 1ps;
   import dram_lane_pkg::*;
   logic            qk_q = 1'b0;
   logic [DQ_W-1:0] rd_q [$];
   // idle pins, clocks standing still
   initial begin
      {o_input_clock, o_dk0, o_dk1, o_mask} = 4'h0;
      {o_cs_n, o_we_n, o_ref_n} = 3'h7;
      o_dq = '0;
   end
   // command held around one input clock rise
   task automatic send_cmd(input logic cs_n, input logic [1:0] we_ref);
      @(negedge i_core_clk);
      o_cs_n = cs_n;
      {o_we_n, o_ref_n} = we_ref;
      repeat (4) @(negedge i_core_clk);
      o_input_clock = 1'b1;
      repeat (4) @(negedge i_core_clk);
      o_input_clock = 1'b0;
      repeat (4) @(negedge i_core_clk);
      o_cs_n = 1'b1;
      {o_we_n, o_ref_n} = ~we_ref;
   endtask : send_cmd
   // one write beat; second data clock trails the first by a cycle
   // data and mask set once per call, held around both clock edges
   task automatic send_beat(input logic [DQ_W-1:0] d, input logic m);
      o_dq = d;
      o_mask = m;
      repeat (2) @(negedge i_core_clk);
      o_dk0 = ~o_dk0;
      @(negedge i_core_clk);
      o_dk1 = ~o_dk1;
      @(negedge i_core_clk);
   endtask : send_beat
   // capture a beat on each output clock edge while valid
   always @(negedge i_core_clk) begin
      if (i_qk !== qk_q && i_read_valid_out === 1'b1)
         rd_q.push_back(i_dq);
      qk_q <= i_qk;
   end
endmodule : ctrl_model

// ---- sim/tb_dram_data_lane_interface.sv ----
`define CHECK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin \
   n_fail++; $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb_dram_data_lane_interface;
   timeunit 1ns;
   timeprecision 1ps;
   import dram_lane_pkg::*;
   logic            clk, rst, ck, cs_n, we_n, ref_n, dk0, dk1, mask, oe, rv;
   logic            rd_ready;
   logic [DQ_W-1:0] dq_in, dq_out, wr_last;
   clk_pair_t       qk0, qk1;
   cmd_t            cmd;
   word_t           wr, rd;
   cmd_kind_t       cmd_last;
   int              n_fail, checks_done, n_wr, n_cmd;
   logic            rv18;
   logic [DQ_W-1:0] dq18, wr18_last, rd18_last;
   word_t           wr18;
   int              n_wr18;
   always #10 clk = ~clk;
   dram_data_lane_interface u_dram_data_lane_interface (.i_core_clk(clk),
      .i_rst(rst), .i_input_clock(ck), .i_cs_n(cs_n), .i_we_n(we_n),
      .i_ref_n(ref_n), .i_input_data_clock0(dk0), .i_input_data_clock1(dk1),
      .i_write_mask_in(mask), .i_dq(dq_in), .o_dq(dq_out), .o_dq_oe(oe),
      .o_output_data_clock0(qk0), .o_output_data_clock1(qk1),
      .o_read_valid_out(rv), .o_cmd(cmd), .o_wr(wr), .i_rd(rd),
      .o_rd_ready(rd_ready));
   ctrl_model u_ctrl_model (.i_core_clk(clk), .i_qk(qk0.clk),
      .i_read_valid_out(rv), .i_dq(dq_out), .o_input_clock(ck),
      .o_cs_n(cs_n), .o_we_n(we_n), .o_ref_n(ref_n), .o_dk0(dk0),
      .o_dk1(dk1), .o_mask(mask), .o_dq(dq_in));
   // narrow build on the same pins: x18 masking and lane mapping
   dram_data_lane_interface #(
      .WIDTH_MODE (MODE_X18)
   ) u_dram_data_lane_interface_x18 (.i_core_clk(clk), .i_rst(rst),
      .i_input_clock(ck), .i_cs_n(cs_n), .i_we_n(we_n), .i_ref_n(ref_n),
      .i_input_data_clock0(dk0), .i_input_data_clock1(dk1),
      .i_write_mask_in(mask), .i_dq(dq_in), .o_dq(dq18), .o_dq_oe(),
      .o_output_data_clock0(), .o_output_data_clock1(),
      .o_read_valid_out(rv18), .o_cmd(), .o_wr(wr18), .i_rd(rd),
      .o_rd_ready());
   // record core side pulses
   always @(negedge clk) begin
      if (wr.valid === 1'b1) begin
         n_wr++;
         wr_last = wr.data;
      end
      if (cmd.valid === 1'b1) begin
         n_cmd++;
         cmd_last = cmd.kind;
      end
      if (wr18.valid === 1'b1) begin
         n_wr18++;
         wr18_last = wr18.data;
      end
      if (rv18 === 1'b1) begin
         rd18_last = dq18;
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish
   task automatic test_cmds();
      logic [1:0] pins [3] = '{2'h1, 2'h2, 2'h0};
      cmd_kind_t  kinds [3] = '{CMD_WRITE, CMD_REFRESH, CMD_MODE_SET};
      for (int i = 0; i < 3; i++) begin
         u_ctrl_model.send_cmd(1'b0, pins[i]);
         @(posedge clk);
         `CHECK("cmd count", i + 1, n_cmd)
         `CHECK("cmd kind", kinds[i], cmd_last)
      end
   endtask : test_cmds
   task automatic test_deselect();
      int n0 = n_cmd;
      u_ctrl_model.send_cmd(1'b1, 2'h1);
      @(posedge clk);
      `CHECK("deselected cmd", n0, n_cmd)
   endtask : test_deselect
   task automatic test_write_mask();
      int n0 = n_wr;
      int n1 = n_wr18;
      u_ctrl_model.send_cmd(1'b0, 2'h1);
      u_ctrl_model.send_beat(36'h9_1234_5678, 1'b0);
      u_ctrl_model.send_beat(36'h6_edcb_a987, 1'b1);
      repeat (8) @(posedge clk);
      `CHECK("wr count", n0 + 1, n_wr)
      `CHECK("wr data", 36'h9_1234_5678, wr_last)
      `CHECK("x18 wr count", n1 + 1, n_wr18)
      `CHECK("x18 wr data", 36'h9_1234_5678 & LIVE_X18, wr18_last)
   endtask : test_write_mask
   task automatic test_read();
      @(negedge clk);
      rd = '{1'b1, 36'hc_0ffe_e001};
      @(negedge clk);
      rd.data = 36'h3_f00d_1e55;
      @(negedge clk);
      rd.valid = 1'b0;
      `CHECK("buffer full", 1'b0, rd_ready)
      u_ctrl_model.send_cmd(1'b0, 2'h3);
      repeat (16) @(posedge clk);
      `CHECK("read kind", CMD_READ, cmd_last)
      `CHECK("beats", 2, u_ctrl_model.rd_q.size())
      `CHECK("beat 0", 36'hc_0ffe_e001, u_ctrl_model.rd_q[0])
      `CHECK("beat 1", 36'h3_f00d_1e55, u_ctrl_model.rd_q[1])
      `CHECK("x18 beat 1", 36'h3_f00d_1e55 & LIVE_X18, rd18_last)
      `CHECK("ready again", 1'b1, rd_ready)
   endtask : test_read
   // reset then the scenarios
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      rd = '0;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      test_cmds();
      test_deselect();
      test_write_mask();
      test_read();
      tally_and_finish();
   end
   // watchdog against a hang
   initial begin
      #50us;
      n_fail++;
      tally_and_finish();
   end
endmodule : tb_dram_data_lane_interface
bind dram_data_lane_interface dram_data_lane_interface_checker
   #(.QK_HALF(QK_HALF)) u_dram_data_lane_interface_checker (.i_core_clk,
   .i_rst, .i_input_clock, .i_cs_n, .o_dq, .o_dq_oe, .o_output_data_clock0,
   .o_output_data_clock1, .o_read_valid_out, .o_cmd, .o_wr);
